// ### rtl/dma_flyby_map.svh
// Constants for the queued fly-by DMA channel
`ifndef DMA_FLYBY_MAP_SVH
`define DMA_FLYBY_MAP_SVH

// ==========================================
// Widths and depths
`define DF_DATA_W 32
`define DF_CNT_W 24
`define DF_OFS_W 8
`define DF_FIFO_DEPTH 16

// ==========================================
// Address stepping and page boundary
`define DF_WORD_BYTES 32'h0000_0004
`define DF_PAGE_LO 2
`define DF_PAGE_HI 9

// ==========================================
// Reset values
`define DF_RST_ADDR 32'h0000_0000
`define DF_RST_CNT 24'h00_0000
`define DF_RST_OFS 8'h00

`endif

// ### rtl/dma_flyby_pkg.sv
// Types shared by the fly-by DMA channel and its buffer
package dma_flyby_pkg;
`include "dma_flyby_map.svh"

   // ==========================================
   // Basic words
   typedef logic [`DF_DATA_W-1:0] word_t;
   typedef logic [`DF_CNT_W-1:0] count_t;
   typedef logic [`DF_OFS_W-1:0] offset_t;

   // ==========================================
   // Peripheral-side burst states, Gray along idle-burst-gap
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_BURST = 2'b01,
      ST_GAP = 2'b11,
      ST_DRAIN = 2'b10
   } burst_state_t;

endpackage

// ### rtl/fifo_if.sv
// Valid/ready carrier between the channel and its word buffer
`timescale 1ns/1ps
interface fifo_if #(parameter int WIDTH = 32);
   logic inValid; // Word offered for storage
   logic inReady; // Buffer has room
   logic [WIDTH-1:0] inData; // Word to store
   logic outValid; // Buffer holds a word
   logic outReady; // Consumer takes the head word
   logic [WIDTH-1:0] outData; // Head word

   // ==========================================
   // Channel side fills and drains the buffer
   modport chan (output inValid, output inData, output outReady,
      input inReady, input outValid, input outData);
   // Buffer side
   modport store (input inValid, input inData, input outReady,
      output inReady, output outValid, output outData);
endinterface

// ### rtl/word_fifo.sv
// Parameterised synchronous word buffer with valid/ready on both sides
`timescale 1ns/1ps
module word_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16
) (
   input wire logic ref_clk, // 100 MHz clock
   input wire logic rstn, // Synchronous reset, active low
   fifo_if.store port // Fill and drain side
);
   import dma_flyby_pkg::*;

   localparam int AW = $clog2(DEPTH);

   // Pointers carry one extra wrap bit for honest full and empty
   typedef struct packed {
      logic [AW:0] wrPtr; // Write pointer
      logic [AW:0] rdPtr; // Read pointer
   } fifo_state_t;

   fifo_state_t s_ff; // Registered state
   fifo_state_t nxt_s; // Next state
   logic [WIDTH-1:0] mem [DEPTH]; // Word storage
   logic full; // No room left
   logic empty; // Nothing stored
   logic doPush; // Word written this cycle
   logic doPop; // Word read this cycle

   // ==========================================
   // Flags and handshakes
   always_comb
   begin
      empty = (s_ff.wrPtr == s_ff.rdPtr);
      full = (s_ff.wrPtr[AW] != s_ff.rdPtr[AW]) &&
         (s_ff.wrPtr[AW-1:0] == s_ff.rdPtr[AW-1:0]);
      doPush = port.inValid && !full;
      doPop = port.outReady && !empty;
      nxt_s = s_ff;
      if (doPush)
      begin
         nxt_s.wrPtr = s_ff.wrPtr + 1'b1;
      end
      if (doPop)
      begin
         nxt_s.rdPtr = s_ff.rdPtr + 1'b1;
      end
   end

   assign port.inReady = !full;
   assign port.outValid = !empty;
   assign port.outData = mem[s_ff.rdPtr[AW-1:0]];

   // ==========================================
   // Pointer registers
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         s_ff <= '0;
      end
      else
      begin
         s_ff <= nxt_s;
      end
   end

   // Storage has no reset; only written words are ever read
   always_ff @(posedge ref_clk)
   begin
      if (doPush)
      begin
         mem[s_ff.wrPtr[AW-1:0]] <= port.inData;
      end
   end
endmodule

// ### rtl/dma_flyby_channel.sv
// One DMA channel: two-entry transfer queue and fly-by burst engine
`timescale 1ns/1ps
`include "dma_flyby_map.svh"

// What this block does
// R01 - Head and tail address/count entries per channel
// R02 - Software loads head, then enables with queue clear
// R03 - Software writes tail count before tail address
// R04 - Queue advance keeps peripheral offset unchanged
// R05 - Tail address write sets queue, clears flag
// R06 - Termination with queue valid advances and restarts
// R07 - Advance clears queue, keeps enable, sets flag
// R08 - Head count shows new transfer after advance
// R09 - Handler only loads tail, never writes control
// R10 - Underflow leaves enable low for software check
// R11 - Termination without queue clears enable
// R12 - Fly-by moves one word per memory cycle
// R13 - Fly-by transfers whole words only
// R14 - Terminate pin ignored as input during fly-by
// R15 - Fly-by request is level sensitive, either polarity
// R16 - Read direction: acknowledge, then mid-cycle output enable
// R17 - Acknowledge low at falling edge accepts request
// R18 - Acknowledge low at rising edge: data next cycle
// R19 - Peripheral holds request half cycle for more
// R20 - Request active at acknowledged cycle end: one more
// R21 - Page mode holds acknowledge up to a 1-Kbyte page end; else two-memory-cycle gap (GAP, then IDLE)
// R22 - Write direction pulses strobe in second half
// R23 - No parity on fly-by data
// R24 - ROM uses same acknowledge, no zero-wait ROM
// R25 - External access request and grant pair
// R26 - Advanced tail counts empty until rewritten
module dma_flyby_channel (
   input wire logic ref_clk, // 100 MHz clock
   input wire logic rstn, // Synchronous reset, active low
   input wire logic headAddrWr, // Head address write strobe
   input wire logic headCountWr, // Head count write strobe
   input wire logic tailAddrWr, // Tail address write strobe
   input wire logic tailCountWr, // Tail count write strobe
   input wire logic ctrlWr, // Control write strobe
   input wire dma_flyby_pkg::word_t wrAddr, // Address write data
   input wire dma_flyby_pkg::count_t wrCount, // Count write data
   input wire logic ctrlEnable, // Control: channel enable
   input wire logic ctrlQueueValid, // Control: queue valid
   input wire logic ctrlTermEnable, // Control: count/ext termination
   input wire logic ctrlDirection, // Control: 0 periph to mem
   input wire logic ctrlFlyBy, // Control: fly-by mode
   input wire logic ctrlReqHigh, // Control: request active high
   input wire logic ctrlPageMode, // Control: page/burst memory
   input wire logic ctrlTermDrive, // Control: drive terminate pin
   input wire dma_flyby_pkg::offset_t ctrlOffset, // Control: offset
   output logic enable, // Channel enable status
   output logic queueValid, // Tail entry valid
   output logic terminationFlag, // Termination interrupt flag
   output dma_flyby_pkg::word_t headAddr, // Head address
   output dma_flyby_pkg::count_t headCount, // Head count
   output dma_flyby_pkg::offset_t peripheralOffset, // Offset field
   output logic parityEnable, // Memory parity permitted
   input wire logic peripheralRequest, // Request pin
   input wire dma_flyby_pkg::word_t peripheralDataIn, // Data bus in
   output dma_flyby_pkg::word_t peripheralDataOut, // Data bus out
   output logic peripheralDataOe, // Data bus drive enable
   output logic peripheralAcknowledgeN, // Acknowledge, active low
   output logic ioChipSelectN, // Peripheral select, active low
   output logic ioOutputEnableN, // Peripheral read enable, low
   output logic ioWriteStrobeN, // Peripheral write strobe, low
   output logic memoryClock, // Memory clock, half ref rate
   input wire logic terminatePinIn, // Terminate pin, active high
   output logic terminatePinOut, // Terminate pin drive value
   output logic terminatePinOe, // Terminate pin drive enable
   input wire logic extAccessRequestN, // External request, low
   input wire logic extAccessDone, // Memory ends external access
   output logic extAccessGrantN, // External grant, active low
   output logic memReq, // Memory access request
   output logic memWrite, // Memory access is a write
   output dma_flyby_pkg::word_t memAddr, // Memory word address
   output dma_flyby_pkg::word_t memWdata, // Memory write data
   input wire logic memAck, // Memory access done
   input wire dma_flyby_pkg::word_t memRdata // Memory read data
);
   import dma_flyby_pkg::*;

   // ==========================================
   // State
   typedef struct packed {
      logic reqS1; // Request synchroniser, first stage
      logic reqS2; // Request synchroniser, second stage
      logic termS1; // Terminate synchroniser, first stage
      logic termS2; // Terminate synchroniser, second stage
      logic extS1; // External request sync, first stage
      logic extS2; // External request sync, second stage
      word_t dinS1; // Data synchroniser, first stage
      word_t dinS2; // Data synchroniser, second stage
      logic phase; // 0 first half, 1 second half
      logic memory_clock; // Memory clock level
      burst_state_t st; // Peripheral-side state
      logic en; // Channel enable
      logic qv; // Tail entry valid
      logic termFlag; // Termination flag
      word_t headAddr; // Head address, peripheral side
      count_t headCount; // Words left minus one
      word_t tailAddr; // Tail address
      count_t tailCount; // Tail count
      offset_t ofs; // Peripheral offset
      logic dir; // Direction
      logic flyBy; // Fly-by mode
      logic reqHigh; // Request polarity
      logic pageMode; // Page/burst memory
      logic termEn; // Count/external termination
      logic termDrive; // Drive terminate pin
      word_t memAddr; // Memory-side address
      logic [`DF_CNT_W:0] memLeft; // Memory words left
      logic memReq; // Memory request
      logic memWrite; // Memory write
      word_t memWdata; // Memory write data
      word_t dout; // Peripheral data out
      logic doutOe; // Peripheral data drive
      logic ackN; // Acknowledge
      logic csN; // Chip select
      logic oeN; // Output enable
      logic weN; // Write strobe
      logic termOut; // Terminate drive value
      logic termOe; // Terminate drive enable
      logic grantN; // External grant
      logic parityEn; // Parity permitted
   } chan_state_t;

   chan_state_t s_ff; // Registered state
   chan_state_t nxt_s; // Next state
   fifo_if #(.WIDTH(`DF_DATA_W)) buf_if (); // Word buffer link
   logic reqActive; // Request at its active level
   logic room; // Buffer can take or give a word
   logic pushPeriph; // Peripheral word into buffer
   logic pushMem; // Memory read word into buffer
   logic popMem; // Buffer word to memory write
   logic popPeriph; // Buffer word to peripheral
   logic termEvt; // Head transfer terminates
   logic qvNow; // Tail valid including this cycle's write
   word_t advAddr; // Tail address taken by an advance
   count_t advCount; // Tail count taken by an advance

   // Last word of a 1-Kbyte page, used for the gap decision
   function automatic logic pageEnd(input word_t a);
      pageEnd = &a[`DF_PAGE_HI:`DF_PAGE_LO];
   endfunction

   // Memory word count from a zero-based count
   function automatic logic [`DF_CNT_W:0] wordsOf(input count_t c);
      wordsOf = {1'b0, c} + {{`DF_CNT_W{1'b0}}, 1'b1};
   endfunction

   // ==========================================
   // Buffer between peripheral and memory
   word_fifo #(.WIDTH(`DF_DATA_W), .DEPTH(`DF_FIFO_DEPTH)) u_fifo (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .port(buf_if.store)
   );

   // ==========================================
   // Next-state logic
   always_comb
   begin
      nxt_s = s_ff;
      pushPeriph = 1'b0;
      pushMem = 1'b0;
      popMem = 1'b0;
      popPeriph = 1'b0;
      termEvt = 1'b0;
      // Pins pass two flops before anything reads them
      nxt_s.reqS1 = peripheralRequest;
      nxt_s.reqS2 = s_ff.reqS1;
      nxt_s.termS1 = terminatePinIn;
      nxt_s.termS2 = s_ff.termS1;
      nxt_s.extS1 = extAccessRequestN;
      nxt_s.extS2 = s_ff.extS1;
      nxt_s.dinS1 = peripheralDataIn;
      nxt_s.dinS2 = s_ff.dinS1;
      // Memory clock: high in first half, low in second
      nxt_s.phase = ~s_ff.phase;
      nxt_s.memory_clock = s_ff.phase;
      reqActive = s_ff.reqHigh ? s_ff.reqS2 : ~s_ff.reqS2; // see R15
      room = s_ff.dir ? buf_if.outValid : buf_if.inReady;
      qvNow = s_ff.qv | tailAddrWr;
      advAddr = tailAddrWr ? wrAddr : s_ff.tailAddr;
      advCount = tailCountWr ? wrCount : s_ff.tailCount;

      // Software writes to head, tail and control
      if (headAddrWr)
      begin
         nxt_s.headAddr = wrAddr;
         nxt_s.memAddr = wrAddr;
      end
      if (headCountWr)
      begin
         nxt_s.headCount = wrCount;
         nxt_s.memLeft = wordsOf(wrCount);
      end
      if (tailCountWr)
      begin
         nxt_s.tailCount = wrCount; // see R01
      end
      if (tailAddrWr)
      begin
         nxt_s.tailAddr = wrAddr; // see R01
         nxt_s.qv = 1'b1; // see R05
         nxt_s.termFlag = 1'b0; // see R05
      end
      if (ctrlWr)
      begin
         nxt_s.en = ctrlEnable;
         nxt_s.qv = ctrlQueueValid;
         nxt_s.termEn = ctrlTermEnable;
         nxt_s.dir = ctrlDirection;
         nxt_s.flyBy = ctrlFlyBy;
         nxt_s.reqHigh = ctrlReqHigh;
         nxt_s.pageMode = ctrlPageMode;
         nxt_s.termDrive = ctrlTermDrive;
         nxt_s.ofs = ctrlOffset;
      end

      // Memory side: one access in flight, whole words only
      if (s_ff.memReq)
      begin
         if (memAck)
         begin
            nxt_s.memReq = 1'b0;
            nxt_s.memAddr = s_ff.memAddr + `DF_WORD_BYTES; // see R13
            pushMem = !s_ff.memWrite;
         end
      end
      else if (s_ff.en && s_ff.flyBy && s_ff.grantN)
      begin
         if (!s_ff.dir && buf_if.outValid)
         begin
            popMem = 1'b1;
            nxt_s.memWdata = buf_if.outData;
            nxt_s.memReq = 1'b1;
            nxt_s.memWrite = 1'b1;
            nxt_s.memLeft = s_ff.memLeft - 1'b1;
         end
         else if (s_ff.dir && s_ff.memLeft != '0 && buf_if.inReady)
         begin
            nxt_s.memReq = 1'b1;
            nxt_s.memWrite = 1'b0;
            nxt_s.memLeft = s_ff.memLeft - 1'b1;
         end
      end

      // Peripheral side burst engine, one word per memory cycle
      nxt_s.weN = 1'b1;
      case (s_ff.st)
         ST_IDLE:
         begin
            // Start only at a period start, never while granted
            if (s_ff.phase && s_ff.en && s_ff.flyBy && reqActive &&
               room && s_ff.grantN)
            begin
               nxt_s.st = ST_BURST;
               nxt_s.ackN = 1'b0; // see R17, R18, R24
               nxt_s.csN = 1'b0; // see R16
               nxt_s.doutOe = s_ff.dir;
            end
         end
         ST_BURST:
         begin
            // Output enable from mid-cycle on, held in page mode up to a page end
            if (!s_ff.dir && !s_ff.phase)
            begin
               nxt_s.oeN = 1'b0; // see R16
            end
            // Strobe only in the second half with valid data
            if (s_ff.dir && !s_ff.phase && buf_if.outValid)
            begin
               nxt_s.weN = 1'b0; // see R22
            end
            nxt_s.termOut = s_ff.termDrive && (s_ff.headCount == '0);
            nxt_s.termOe = s_ff.termDrive;
            // Write side waits for its strobe
            if (s_ff.phase && (s_ff.dir ? !s_ff.weN : room))
            begin
               // Word completes; no parity applies to it
               pushPeriph = !s_ff.dir; // see R12, R23
               popPeriph = s_ff.dir; // see R12
               nxt_s.headAddr = s_ff.headAddr + `DF_WORD_BYTES;
               if (s_ff.headCount == '0)
               begin
                  nxt_s.st = ST_DRAIN;
               end
               else
               begin
                  nxt_s.headCount = s_ff.headCount - 1'b1;
                  if (!reqActive)
                  begin
                     nxt_s.st = ST_IDLE; // see R19, R20
                  end
                  else if (!s_ff.pageMode || pageEnd(s_ff.headAddr))
                  begin
                     nxt_s.st = ST_GAP; // see R21
                  end
               end
               if (nxt_s.st != ST_BURST)
               begin
                  nxt_s.ackN = 1'b1;
                  nxt_s.oeN = 1'b1;
                  nxt_s.csN = 1'b1;
                  nxt_s.doutOe = 1'b0;
                  nxt_s.termOut = 1'b0;
               end
            end
         end
         ST_GAP:
         begin
            // One full memory cycle with acknowledge released
            if (s_ff.phase)
            begin
               nxt_s.st = ST_IDLE; // see R21
            end
         end
         ST_DRAIN:
         begin
            // Terminate only once memory holds every word
            nxt_s.termOe = 1'b0;
            if (s_ff.memLeft == '0 && !s_ff.memReq && !buf_if.outValid)
            begin
               nxt_s.st = ST_IDLE;
               termEvt = s_ff.termEn;
               nxt_s.en = s_ff.termEn ? s_ff.en : 1'b0;
            end
         end
         default:
         begin
            nxt_s.st = ST_IDLE;
         end
      endcase

      // External terminate counts only outside fly-by
      if (!s_ff.flyBy && s_ff.termEn && s_ff.en && s_ff.termS2)
      begin
         termEvt = 1'b1; // see R14
      end

      // Termination: advance the queue or stop the channel
      if (termEvt)
      begin
         nxt_s.termFlag = 1'b1; // see R07
         if (qvNow)
         begin
            nxt_s.headAddr = advAddr; // see R06, R04
            nxt_s.memAddr = advAddr; // see R06
            nxt_s.headCount = advCount; // see R08
            nxt_s.memLeft = wordsOf(advCount); // see R08
            nxt_s.qv = 1'b0; // see R07, R26
            nxt_s.en = 1'b1; // see R07
         end
         else
         begin
            nxt_s.en = 1'b0; // see R10, R11
         end
      end

      // External master access, granted only while the channel idles
      if (s_ff.grantN)
      begin
         if (!s_ff.extS2 && s_ff.st == ST_IDLE &&
            nxt_s.st == ST_IDLE && !s_ff.memReq && !nxt_s.memReq)
         begin
            nxt_s.grantN = 1'b0; // see R25
         end
      end
      else if (extAccessDone)
      begin
         nxt_s.grantN = 1'b1; // see R25
      end

      nxt_s.dout = buf_if.outData;
      nxt_s.parityEn = !(s_ff.en && s_ff.flyBy); // see R23
   end

   // Buffer handshakes from the two directions
   assign buf_if.inValid = pushPeriph || pushMem;
   assign buf_if.inData = pushMem ? memRdata : s_ff.dinS2;
   assign buf_if.outReady = popMem || popPeriph;

   // ==========================================
   // State register
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         s_ff <= '0;
         s_ff.st <= ST_IDLE;
         s_ff.headAddr <= `DF_RST_ADDR;
         s_ff.tailAddr <= `DF_RST_ADDR;
         s_ff.memAddr <= `DF_RST_ADDR;
         s_ff.headCount <= `DF_RST_CNT;
         s_ff.tailCount <= `DF_RST_CNT;
         s_ff.ofs <= `DF_RST_OFS;
         s_ff.ackN <= 1'b1;
         s_ff.csN <= 1'b1;
         s_ff.oeN <= 1'b1;
         s_ff.weN <= 1'b1;
         s_ff.grantN <= 1'b1;
         s_ff.parityEn <= 1'b1;
         s_ff.extS1 <= 1'b1;
         s_ff.extS2 <= 1'b1;
      end
      else
      begin
         s_ff <= nxt_s;
      end
   end

   // ==========================================
   // Outputs straight from the state register
   assign enable = s_ff.en;
   assign queueValid = s_ff.qv;
   assign terminationFlag = s_ff.termFlag;
   assign headAddr = s_ff.headAddr;
   assign headCount = s_ff.headCount;
   assign peripheralOffset = s_ff.ofs;
   assign parityEnable = s_ff.parityEn;
   assign peripheralDataOut = s_ff.dout;
   assign peripheralDataOe = s_ff.doutOe;
   assign peripheralAcknowledgeN = s_ff.ackN;
   assign ioChipSelectN = s_ff.csN;
   assign ioOutputEnableN = s_ff.oeN;
   assign ioWriteStrobeN = s_ff.weN;
   assign memoryClock = s_ff.memory_clock;
   assign terminatePinOut = s_ff.termOut;
   assign terminatePinOe = s_ff.termOe;
   assign extAccessGrantN = s_ff.grantN;
   assign memReq = s_ff.memReq;
   assign memWrite = s_ff.memWrite;
   assign memAddr = s_ff.memAddr;
   assign memWdata = s_ff.memWdata;
endmodule

// ### tb/dma_flyby_channel_chk.sv
// Port-level assertions for the fly-by DMA channel
`timescale 1ns/1ps
module dma_flyby_channel_chk (
   input wire logic ref_clk, // Clock
   input wire logic rstn, // Reset, low
   input wire logic ctrlWr, // Control write
   input wire logic tailAddrWr, // Tail address write
   input wire logic enable, // Enable
   input wire logic queueValid, // Queue valid
   input wire logic terminationFlag, // Flag
   input wire dma_flyby_pkg::offset_t peripheralOffset, // Offset
   input wire logic parityEnable, // Parity
   input wire logic peripheralAcknowledgeN, // Ack
   input wire logic ioOutputEnableN, // Read enable
   input wire logic ioWriteStrobeN, // Write strobe
   input wire logic memoryClock, // Memory clock
   input wire logic memReq, // Memory request
   input wire logic memAck, // Memory done
   input wire dma_flyby_pkg::word_t memAddr // Memory address
);
   import dma_flyby_pkg::*;
   // ==========================================
   // Properties
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   // Steps of a burst start and of a memory wait
   sequence ackStart;
      $fell(peripheralAcknowledgeN);
   endsequence
   sequence memWait;
      memReq && !memAck;
   endsequence
   tail_set_a: assert property (tailAddrWr && !enable |=>
      queueValid && !terminationFlag) else $error("tail write");
   q_advance_a: assert property ($fell(queueValid) && !$past(ctrlWr)
      |-> enable && terminationFlag) else $error("advance");
   en_clear_a: assert property ($fell(enable) && !$past(ctrlWr)
      |-> terminationFlag && !queueValid) else $error("underflow");
   offset_keep_a: assert property (!$past(ctrlWr) |->
      $stable(peripheralOffset)) else $error("offset moved");
   parity_off_a: assert property (!peripheralAcknowledgeN
      |-> !parityEnable) else $error("parity in fly-by");
   ack_first_a: assert property (ackStart |-> ioOutputEnableN)
      else $error("oe with ack");
   oe_in_ack_a: assert property ($fell(ioOutputEnableN)
      |-> !peripheralAcknowledgeN) else $error("oe without ack");
   strobe_half_a: assert property (!ioWriteStrobeN |->
      !memoryClock) else $error("strobe phase");
   mem_hold_a: assert property (memWait |=> memReq &&
      $stable(memAddr)) else $error("mem request dropped");
   mem_gap_a: assert property (memReq && memAck |=> !memReq)
      else $error("mem gap");
endmodule
bind dma_flyby_channel dma_flyby_channel_chk u_chk (.*);

// ### tb/periph_model.sv
// Behavioural fly-by peripheral: level request and data bus
`timescale 1ns/1ps
module periph_model (
   input wire logic ref_clk, // Clock
   input wire logic want, // Bench wants words
   input wire logic reqHigh, // Request polarity
   input wire logic ioOutputEnableN, // Read enable
   output logic request, // Request pin
   output dma_flyby_pkg::word_t dataOut // Data bus
);
   import dma_flyby_pkg::*;
   // Level request held while more words are wanted
   assign request = want ~^ reqHigh;
   // Undriven bus keeps changing so stale data never matches
   initial dataOut = '0;
   always @(posedge ref_clk)
      dataOut <= ioOutputEnableN ? ~dataOut : dataOut + 32'h1;
endmodule

// ### tb/dma_flyby_channel_bench.sv
// Self-checking bench for the queued fly-by DMA channel
`timescale 1ns/1ps
module dma_flyby_channel_bench;
   import dma_flyby_pkg::*;
   // ==========================================
   // Signals
   logic ref_clk='0, rstn='0, headAddrWr='0, headCountWr='0;
   logic tailAddrWr='0, tailCountWr='0, ctrlWr='0, ctrlEnable='1;
   logic ctrlQueueValid='0, ctrlTermEnable='1, ctrlDirection='0;
   logic ctrlFlyBy='1, ctrlReqHigh='1, ctrlPageMode='1, ctrlTermDrive='1;
   logic terminatePinIn='1, memAck='0, extAccessRequestN='1;
   logic extAccessDone='0, want='0, enable, queueValid, terminationFlag;
   logic parityEnable, peripheralRequest, peripheralDataOe, memWrite;
   logic peripheralAcknowledgeN, ioChipSelectN, ioOutputEnableN;
   logic ioWriteStrobeN, memoryClock, terminatePinOut, terminatePinOe;
   logic extAccessGrantN, memReq;
   word_t wrAddr='0, headAddr, peripheralDataIn, peripheralDataOut;
   word_t memAddr, memWdata, memRdata='0, base, mLog[$];
   count_t wrCount='0, headCount;
   offset_t ctrlOffset='0, peripheralOffset;
   int bad_count=0, comparisons=0, strobes=0, cyc=0, i, k, n, seed=92;
   dma_flyby_channel u_dut (.*);
   periph_model u_per (.ref_clk, .want, .reqHigh(ctrlReqHigh),
      .ioOutputEnableN, .request(peripheralRequest),
      .dataOut(peripheralDataIn));
   always #5 ref_clk = ~ref_clk;
   // Memory with random latency; logs accesses and strobes
   always @(posedge ref_clk)
   begin
      if (memReq && memAck) mLog.push_back(memAddr);
      if (ioWriteStrobeN === 1'b0) strobes++;
      cyc++;
      if (cyc == 40000)
      begin
         bad_count++;
         report_and_stop;
      end
      else
      begin
         #1;
         memAck = memReq && !memAck && $random(seed) & 1;
         memRdata = $random(seed);
      end
   end
   // ==========================================
   // Tasks
   function word_t nthAddr(input word_t b, input int j);
      return b + 32'(j) * 32'h4;
   endfunction
   task step;
      @(posedge ref_clk);
      #1;
   endtask
   task put(input logic [4:0] s, input word_t a, input count_t c);
      step;
      {ctrlWr, tailCountWr, tailAddrWr, headCountWr, headAddrWr} = s;
      wrAddr = a;
      wrCount = c;
      step;
      {ctrlWr, tailCountWr, tailAddrWr, headCountWr, headAddrWr} = '0;
   endtask
   task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e)
      begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task report_and_stop;
      if (bad_count == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // ==========================================
   // Sequence
   initial
   begin
      repeat (12) @(posedge ref_clk);
      #1 rstn = '1;
      // Queued periph-to-memory burst, terminate pin held active
      ctrlOffset = 8'($random(seed));
      put(5'h01, 32'h100, '0);
      put(5'h02, '0, 24'h1);
      put(5'h10, '0, '0);
      put(5'h08, '0, '0);
      put(5'h04, 32'h200, '0);
      chk("queueValid", 32'(queueValid), 32'h1);
      want = '1;
      for (i = 0; i < 900 && queueValid !== 1'b0; i++) step;
      chk("enable", 32'(enable), 32'h1);
      chk("flag", 32'(terminationFlag), 32'h1);
      chk("headAddr", headAddr, 32'h200);
      chk("headCount", 32'(headCount), 32'h0);
      for (i = 0; i < 900 && enable !== 1'b0; i++) step;
      chk("underflow", 32'(terminationFlag), 32'h1);
      chk("offset", 32'(peripheralOffset), 32'(ctrlOffset));
      chk("writes", 32'(mLog.size()), 32'h3);
      chk("memAddr0", mLog[0], nthAddr(32'h100, 0));
      chk("memAddr1", mLog[1], nthAddr(32'h100, 1));
      chk("memAddr2", mLog[2], 32'h200);
      want = '0;
      put(5'h04, 32'h300, '0);
      // Memory-to-periph bursts, active-low request, random sizes
      for (k = 0; k < 4; k++)
      begin
         n = $random(seed) & 3;
         base = $random(seed) & 32'hffc;
         {ctrlDirection, ctrlReqHigh, ctrlQueueValid} = 3'b100;
         ctrlPageMode = 1'($random(seed));
         terminatePinIn = k[0];
         mLog.delete();
         strobes = 0;
         put(5'h01, base, '0);
         put(5'h02, '0, 24'(n));
         put(5'h10, '0, '0);
         want = '1;
         for (i = 0; i < 900 && enable !== 1'b0; i++) step;
         want = '0;
         repeat (6) step;
         chk("reads", 32'(mLog.size()), 32'(n + 1));
         chk("strobes", 32'(strobes), 32'(n + 1));
         for (i = 0; i <= n; i++)
            chk("rdAddr", mLog[i], nthAddr(base, i));
      end
      // External access request and grant
      extAccessRequestN = '0;
      for (i = 0; i < 100 && extAccessGrantN !== 1'b0; i++) step;
      chk("grant", 32'(extAccessGrantN), 32'h0);
      extAccessRequestN = '1;
      repeat (3) step;
      extAccessDone = '1;
      step;
      extAccessDone = '0;
      repeat (4) step;
      chk("release", 32'(extAccessGrantN), 32'h1);
      report_and_stop;
   end
endmodule
